// file: pkg/plb_pkg.sv
// Shared constants and types for the programmable logic block
package plb_pkg;
  // ----------------------------------------
  // Block shape
  // ----------------------------------------
  localparam int NumSlices = 4;   // Slices 0..3
  localparam int RegSlices = 3;   // Slices with registers and carry
  localparam int SliceInW  = 13;  // Routing inputs of slices 0..2
  localparam int TopInW    = 10;  // Routing inputs of slice 3
  localparam int SliceOutW = 6;   // Routing outputs of slices 0..2
  localparam int TopOutW   = 4;   // Routing outputs of slice 3
  localparam int BlockInW  = 50;  // All block inputs
  localparam int BlockOutW = 23;  // All block outputs
  localparam int LutW      = 16;  // Entries of one four-input table
  // ----------------------------------------
  // Pin positions inside a slice input word
  // ----------------------------------------
  localparam int PinLut0 = 0;     // Table 0 address, 4 bits
  localparam int PinLut1 = 4;     // Table 1 address, 4 bits
  localparam int PinM0   = 8;     // Select / data bit 0
  localparam int PinM1   = 9;     // Select / data bit 1
  localparam int PinClk  = 10;    // Routing clock
  localparam int PinLsr  = 11;    // Set/reset request
  localparam int PinCe   = 12;    // Clock enable / write enable
  // ----------------------------------------
  // Output positions inside a slice output word
  // ----------------------------------------
  localparam int OutF    = 0;     // Two table results
  localparam int OutQ    = 2;     // Two register results
  localparam int OutOfx0 = 4;     // Five-input merge
  localparam int OutOfx1 = 5;     // Wider merge
  // ----------------------------------------
  // Mode word fields and register map
  // ----------------------------------------
  localparam int FldMode   = 0;   // Two bits
  localparam int FldClkNeg = 2;   // Clock polarity
  localparam int FldLevel  = 3;   // Level sensitive
  localparam int FldAsync  = 4;   // Set/reset asynchronous
  localparam int FldSrVal  = 5;   // Two bits, value forced by set/reset
  localparam int FldBypass = 7;   // Register loads select bits
  localparam int FldShared = 8;   // Clock from slice 0 pin
  localparam int ModeW     = 9;
  localparam logic [ModeW-1:0] ModeReset = 9'h000;
  localparam int AdrW = 8;
  localparam logic [3:0] RegionLut  = 4'h0;  // 0x00..0x0c table words
  localparam logic [3:0] RegionMode = 4'h1;  // 0x10..0x1c mode words
  localparam logic [AdrW-1:0] AdrCtrl   = 8'h20;
  localparam logic [AdrW-1:0] AdrStatus = 8'h24;
  // Slice operating modes
  typedef enum logic [1:0] {
    ModeLogic  = 2'b00,
    ModeRipple = 2'b01,
    ModeRam    = 2'b11,
    ModeRom    = 2'b10
  } plb_mode_t;
endpackage

// file: pkg/plb_cfg_if.sv
// Configuration carrier between the block top and one slice
`timescale 1ns/1ps
interface plb_cfg_if;
  logic [31:0]               lutInit;    // Table image to load
  logic                      lutLoad;    // Load strobe, one cycle
  logic [plb_pkg::ModeW-1:0] modeWord;   // Mode and register options
  logic                      sharedClk;  // Slice 0 routing clock
  logic                      chipSel;    // Memory write gate
  logic [31:0]               lutNow;     // Current table image
  modport ctrl  (output lutInit, lutLoad, modeWord, sharedClk, chipSel, input lutNow);
  modport slice (input lutInit, lutLoad, modeWord, sharedClk, chipSel, output lutNow);
endinterface

// file: logic/plb_sync.sv
// Two-stage synchroniser for routing inputs
`timescale 1ns/1ps
module plb_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;       // First stage, read only by q
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // Next stage values
  always_comb begin
    next_meta = rst ? '0 : d;
    next_q    = rst ? '0 : meta;
  end

  // Stage registers
  always_ff @(posedge clock) begin
    meta <= next_meta;
    q    <= next_q;
  end
endmodule

// file: logic/plb_slice.sv
// One slice: two four-input tables, optional registers and carry
`timescale 1ns/1ps
module plb_slice #(
  parameter bit HAS_REG = 1'b1,
  parameter bit RAM_OK  = 1'b1
) (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst,
  // Configuration
  plb_cfg_if.slice                           cfg,
  // Routing side
  input  wire logic [plb_pkg::SliceInW-1:0]  din,
  input  wire logic                          cin,
  output logic      [1:0]                    f,
  output logic      [1:0]                    q,
  output logic                               ofx0,
  output logic                               cout
);
  // ----------------------------------------
  // State and decode
  // ----------------------------------------
  logic [1:0][plb_pkg::LutW-1:0] tbl;       // Table contents
  logic [1:0][plb_pkg::LutW-1:0] next_tbl;
  logic [1:0]          next_q;
  logic                prevLvl;             // Clock level last cycle
  logic                next_prevLvl;
  plb_pkg::plb_mode_t  mode;                // Requested mode
  plb_pkg::plb_mode_t  modeEff;             // Mode this slice can do
  logic [1:0]          p;                   // Raw table results
  logic                c1;                  // Carry between halves
  logic                lvl;                 // Clock level after polarity
  logic                tick;                // Active clock event
  logic                lsr;
  logic                async;
  logic                ramWe;
  logic [1:0]          srVal;

  assign mode  = plb_pkg::plb_mode_t'(cfg.modeWord[plb_pkg::FldMode +: 2]);
  assign async = cfg.modeWord[plb_pkg::FldAsync];
  assign srVal = cfg.modeWord[plb_pkg::FldSrVal +: 2];
  assign lsr   = din[plb_pkg::PinLsr];
  assign cfg.lutNow = tbl;

  // Unsupported modes fall back to plain logic
  always_comb begin
    modeEff = mode;
    if (mode == plb_pkg::ModeRam && !(HAS_REG && RAM_OK)) begin
      modeEff = plb_pkg::ModeLogic;
    end
    if (mode == plb_pkg::ModeRipple && !HAS_REG) begin
      modeEff = plb_pkg::ModeLogic;
    end
  end

  // ----------------------------------------
  // Tables, ripple and merge
  // ----------------------------------------
  always_comb begin
    p[0] = tbl[0][din[plb_pkg::PinLut0 +: 4]];
    p[1] = tbl[1][din[plb_pkg::PinLut1 +: 4]];
    c1   = 1'b0;
    cout = 1'b0;                    // No chain unless rippling
    f    = p;
    if (modeEff == plb_pkg::ModeRipple) begin
      // Table gives propagate, first address bit gives generate
      f[0] = p[0] ^ cin;
      c1   = p[0] ? cin : din[plb_pkg::PinLut0];
      f[1] = p[1] ^ c1;
      cout = p[1] ? c1 : din[plb_pkg::PinLut1];
    end
    ofx0 = din[plb_pkg::PinM0] ? p[1] : p[0];
  end

  // ----------------------------------------
  // Clock select, polarity and edge/level
  // ----------------------------------------
  always_comb begin
    lvl = (cfg.modeWord[plb_pkg::FldShared] ? cfg.sharedClk : din[plb_pkg::PinClk])
          ^ cfg.modeWord[plb_pkg::FldClkNeg];
    // Level mode follows the input while the level is active
    tick = cfg.modeWord[plb_pkg::FldLevel] ? lvl : (lvl & ~prevLvl);
    ramWe = (modeEff == plb_pkg::ModeRam) && tick && din[plb_pkg::PinCe] && cfg.chipSel;
  end

  // Next table, register and clock history
  always_comb begin
    next_prevLvl = rst ? 1'b0 : lvl;
    next_tbl     = tbl;
    next_q       = q;
    if (cfg.lutLoad) begin
      next_tbl = cfg.lutInit;
    end
    if (ramWe) begin
      // Memory write wins over a bus load in the same cycle
      next_tbl[0][din[plb_pkg::PinLut1 +: 4]] = din[plb_pkg::PinM0];
      next_tbl[1][din[plb_pkg::PinLut1 +: 4]] = din[plb_pkg::PinM1];
    end
    if (HAS_REG) begin
      if (lsr && (async || tick)) begin
        next_q = srVal;
      end else if (tick && din[plb_pkg::PinCe]) begin
        next_q = cfg.modeWord[plb_pkg::FldBypass] ? din[plb_pkg::PinM0 +: 2] : f;
      end
    end else begin
      next_q = 2'h0;
    end
    if (rst) begin
      next_tbl = '0;
      next_q   = 2'h0;
    end
  end

  // Slice registers
  always_ff @(posedge clock) begin
    tbl     <= next_tbl;
    q       <= next_q;
    prevLvl <= next_prevLvl;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  ramWrite_a: assert property (ramWe |=> tbl[1][$past(din[plb_pkg::PinLut1 +: 4])] == $past(din[plb_pkg::PinM1]))
    else $error("memory write not stored");
  noRam_a: assert property (ramWe |-> HAS_REG && RAM_OK)
    else $error("memory write in a slice without memory");
  asyncSet_a: assert property (HAS_REG && async && lsr |=> q == $past(srVal))
    else $error("asynchronous set/reset missed");
  edgeHold_a: assert property (!tick && !(lsr && async) |=> $stable(q))
    else $error("register changed without clock event");
  noChain_a: assert property (!HAS_REG |-> !cout && modeEff != plb_pkg::ModeRipple)
    else $error("slice without registers rippled");
endmodule

// file: logic/plb_logic_block.sv
// Programmable logic block: four slices, wide merge and bus configuration
//
// Behaviour
// - Four slices, two tables each
// - Slices 0-2 registered, slice 3 tables only
// - Memory mode only in memory-capable variant
// - Mode set per slice and variant
// - Tables merge into five to eight inputs
// - Set/reset, synchronous or asynchronous per slice
// - Clock select, chip select, wide memory control
// - Clock polarity and edge or level
// - Slices 0-2: thirteen inputs plus carry
// - Slices 0-2: six outputs plus carry
// - Slice 3: ten in, four out, no carry
// - Fifty inputs, twenty-three outputs, all routing
//
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module plb_logic_block #(
  parameter bit RAM_CAPABLE = 1'b1
) (
  // Clock and reset
  input  wire logic                                  clock,
  input  wire logic                                  rst,
  // Wishbone slave
  input  wire logic                                  cyc_i,
  input  wire logic                                  stb_i,
  input  wire logic                                  we_i,
  input  wire logic [plb_pkg::AdrW-1:0]              adr_i,
  input  wire logic [3:0]                            sel_i,
  input  wire logic [31:0]                           dat_i,
  output logic      [31:0]                           dat_o,
  output logic                                       ack_o,
  // Routing inputs
  input  wire logic [plb_pkg::RegSlices*plb_pkg::SliceInW-1:0] fabricIn,
  input  wire logic [plb_pkg::TopInW-1:0]            topIn,
  input  wire logic                                  carryIn,
  // Routing outputs
  output logic [plb_pkg::RegSlices*plb_pkg::SliceOutW-1:0] fabricOut,
  output logic [plb_pkg::TopOutW-1:0]                topOut,
  output logic                                       carryOut
);
  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic [plb_pkg::BlockInW-1:0]  syncIn;     // All fifty inputs, synchronised
  logic [plb_pkg::NumSlices-1:0][plb_pkg::SliceInW-1:0] pins; // Per slice inputs

  // Routing pins come from other clocking, so everything is resampled
  plb_sync #(
    .W (plb_pkg::BlockInW)
  ) inSync (
    .clock (clock),
    .rst   (rst),
    .d     ({carryIn, topIn, fabricIn}),
    .q     (syncIn)
  );

  // Split inputs per slice; slice 3 upper pins unused
  always_comb begin
    for (int i = 0; i < plb_pkg::RegSlices; i++) begin
      pins[i] = syncIn[i*plb_pkg::SliceInW +: plb_pkg::SliceInW];
    end
    pins[plb_pkg::RegSlices] = {3'h0, syncIn[plb_pkg::RegSlices*plb_pkg::SliceInW +: plb_pkg::TopInW]};
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [plb_pkg::NumSlices-1:0][plb_pkg::ModeW-1:0] modeReg;   // Per slice mode word
  logic [plb_pkg::NumSlices-1:0][plb_pkg::ModeW-1:0] next_modeReg;
  logic                chipSel;           // Memory write gate
  logic                next_chipSel;
  logic                next_ack;
  logic [31:0]         next_dat;
  logic                wbWrite;           // Accepted write this cycle
  logic                wbTake;            // Accepted access this cycle
  logic [31:0]         mask;              // Byte lane mask
  logic [1:0]          idx;               // Slice index of access
  logic [3:0]          region;            // Upper address nibble
  logic [plb_pkg::NumSlices-1:0][31:0] lutNow;   // Table readback
  logic [plb_pkg::NumSlices-1:0]       lutLoad;  // Table load strobes

  assign wbTake  = cyc_i && stb_i && !ack_o;
  assign wbWrite = wbTake && we_i;
  assign idx     = adr_i[3:2];
  assign region  = adr_i[7:4];

  // Byte enables widened to bit mask
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      mask[b*8 +: 8] = {8{sel_i[b]}};
    end
  end

  // Table load strobes, one per slice
  always_comb begin
    for (int i = 0; i < plb_pkg::NumSlices; i++) begin
      lutLoad[i] = wbWrite && region == plb_pkg::RegionLut && idx == i[1:0];
    end
  end

  // Bus answer, mode words and control bit
  always_comb begin
    next_ack     = wbTake;           // Ack one cycle after request
    next_dat     = dat_o;
    next_modeReg = modeReg;
    next_chipSel = chipSel;
    if (wbTake && !we_i) begin
      unique case (region)
        plb_pkg::RegionLut:  next_dat = lutNow[idx];
        plb_pkg::RegionMode: next_dat = {23'h0, modeReg[idx]};
        default: begin
          // Unmapped reads answer zero
          next_dat = 32'h0;
          if (adr_i == plb_pkg::AdrCtrl) begin
            next_dat = {31'h0, chipSel};
          end else if (adr_i == plb_pkg::AdrStatus) begin
            next_dat = {9'h0, carryOut, topOut, fabricOut};
          end
        end
      endcase
    end
    if (wbWrite && region == plb_pkg::RegionMode) begin
      next_modeReg[idx] = (modeReg[idx] & ~mask[plb_pkg::ModeW-1:0])
                          | (dat_i[plb_pkg::ModeW-1:0] & mask[plb_pkg::ModeW-1:0]);
    end
    if (wbWrite && adr_i == plb_pkg::AdrCtrl && sel_i[0]) begin
      next_chipSel = dat_i[0];
    end
    if (rst) begin
      next_ack     = 1'b0;
      next_dat     = 32'h0;
      next_modeReg = {plb_pkg::NumSlices{plb_pkg::ModeReset}};
      next_chipSel = 1'b0;
    end
  end

  // Configuration and bus registers
  always_ff @(posedge clock) begin
    ack_o   <= next_ack;
    dat_o   <= next_dat;
    modeReg <= next_modeReg;
    chipSel <= next_chipSel;
  end

  // ----------------------------------------
  // Slices
  // ----------------------------------------
  logic [plb_pkg::NumSlices-1:0][1:0] f;     // Table results
  logic [plb_pkg::NumSlices-1:0][1:0] q;     // Register results
  logic [plb_pkg::NumSlices-1:0]      ofx0;  // Five-input merges
  logic [plb_pkg::NumSlices-1:0]      ofx1;  // Wider merges
  logic [plb_pkg::NumSlices-1:0]      cout;  // Carry out per slice

  for (genvar i = 0; i < plb_pkg::NumSlices; i++) begin : gSlice
    plb_cfg_if cfg ();
    // Partial table writes keep the unselected bytes
    assign cfg.lutInit   = (lutNow[i] & ~mask) | (dat_i & mask);
    assign cfg.lutLoad   = lutLoad[i];
    assign cfg.modeWord  = modeReg[i];
    assign cfg.sharedClk = pins[0][plb_pkg::PinClk];
    assign cfg.chipSel   = chipSel;
    assign lutNow[i]     = cfg.lutNow;

    plb_slice #(
      .HAS_REG (i < plb_pkg::RegSlices),
      .RAM_OK  (RAM_CAPABLE)
    ) slice (
      .clock (clock),
      .rst   (rst),
      .cfg   (cfg.slice),
      .din   (pins[i]),
      // Chain runs 0 to 2; slice 3 stays off it
      .cin   ((i == 0) ? syncIn[plb_pkg::BlockInW-1] :
              (i < plb_pkg::RegSlices) ? cout[(i+plb_pkg::NumSlices-1)%plb_pkg::NumSlices] : 1'b0),
      .f     (f[i]),
      .q     (q[i]),
      .ofx0  (ofx0[i]),
      .cout  (cout[i])
    );
  end

  // ----------------------------------------
  // Wide function merge
  // ----------------------------------------
  // Pairs give six inputs, pairs of pairs seven, top stage eight
  always_comb begin
    ofx1[0] = pins[0][plb_pkg::PinM1] ? ofx0[1] : ofx0[0];
    ofx1[2] = pins[2][plb_pkg::PinM1] ? ofx0[3] : ofx0[2];
    ofx1[1] = pins[1][plb_pkg::PinM1] ? ofx1[2] : ofx1[0];
    ofx1[3] = pins[3][plb_pkg::PinM1] ? ofx1[1] : ofx0[3];
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  logic [plb_pkg::BlockOutW-1:0] outBus;      // Registered outputs
  logic [plb_pkg::BlockOutW-1:0] next_outBus;

  // Gather every result toward routing
  always_comb begin
    next_outBus = '0;
    for (int i = 0; i < plb_pkg::RegSlices; i++) begin
      next_outBus[i*plb_pkg::SliceOutW +: plb_pkg::SliceOutW] = {ofx1[i], ofx0[i], q[i], f[i]};
    end
    next_outBus[plb_pkg::RegSlices*plb_pkg::SliceOutW +: plb_pkg::TopOutW] =
      {ofx1[plb_pkg::RegSlices], ofx0[plb_pkg::RegSlices], f[plb_pkg::RegSlices]};
    next_outBus[plb_pkg::BlockOutW-1] = cout[plb_pkg::RegSlices-1];
    if (rst) begin
      next_outBus = '0;
    end
  end

  // Outputs change only on the system clock
  always_ff @(posedge clock) begin
    outBus <= next_outBus;
  end

  assign fabricOut = outBus[plb_pkg::RegSlices*plb_pkg::SliceOutW-1:0];
  assign topOut    = outBus[plb_pkg::BlockOutW-2 -: plb_pkg::TopOutW];
  assign carryOut  = outBus[plb_pkg::BlockOutW-1];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  ackPulse_a: assert property (@(posedge clock) disable iff (rst) ack_o |=> !ack_o)
    else $error("ack held more than one cycle");
  ackAnswer_a: assert property (@(posedge clock) disable iff (rst) cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered");
  sixMerge_a: assert property (@(posedge clock) disable iff (rst)
    !rst |=> fabricOut[plb_pkg::OutOfx1] == $past(pins[0][plb_pkg::PinM1] ? ofx0[1] : ofx0[0]))
    else $error("six-input merge wrong");
  carryPath_a: assert property (@(posedge clock) disable iff (rst)
    !rst |=> carryOut == $past(cout[2]))
    else $error("block carry out wrong");
endmodule

// file: bench/plb_fabric.sv
// Routing-fabric model that drives the block's input pins
`timescale 1ns/1ps
module plb_fabric (
  // Clock
  input  wire logic                                         clock,
  // Pins toward the block
  output logic [plb_pkg::RegSlices*plb_pkg::SliceInW-1:0]   fabricIn,
  output logic [plb_pkg::TopInW-1:0]                        topIn,
  output logic                                              carryIn
);
  // Idle fabric: every pin low, routing clocks still
  initial begin
    fabricIn = '0;
    topIn    = '0;
    carryIn  = 1'b0;
  end
  // Replace a whole slice word just after an edge
  task automatic set_slice(input int s, input logic [12:0] v);
    @(posedge clock);
    fabricIn[13*s +: 13] <= v;
  endtask
  // Slice 3 word
  task automatic set_top(input logic [9:0] v);
    @(posedge clock);
    topIn <= v;
  endtask
  // Carry into slice 0
  task automatic set_carry(input logic v);
    @(posedge clock);
    carryIn <= v;
  endtask
  // Routing clock level held 4 cycles, past the 2-cycle minimum
  task automatic set_clk(input int s, input logic v);
    @(posedge clock);
    fabricIn[13*s+plb_pkg::PinClk] <= v;
    repeat (3) @(posedge clock);
  endtask
endmodule

// file: bench/tb_plb_logic_block.sv
// Self-checking bench for the programmable logic block
`timescale 1ns/1ps
module tb_plb_logic_block;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clock;       // 25 MHz system clock
  logic        rst;         // Synchronous reset
  logic        cyc;         // Bus cycle
  logic        stb;         // Bus strobe
  logic        we;          // Bus direction
  logic [7:0]  adr;         // Bus address
  logic [3:0]  sel;         // Byte lanes
  logic [31:0] wdat;        // Write data
  logic [31:0] rdat;        // Read data
  logic        ack;         // Bus answer
  logic [38:0] fabricIn;    // Slices 0..2 pins
  logic [9:0]  topIn;       // Slice 3 pins
  logic        carryIn;     // Carry into slice 0
  logic [17:0] fabricOut;   // Slices 0..2 results
  logic [3:0]  topOut;      // Slice 3 results
  logic        carryOut;    // Carry out of slice 2
  logic [31:0] got;         // Last word read
  int          mismatches;  // Failed comparisons
  int          num_checks;  // All comparisons
  // ----------------------------------------
  // Instances and clock
  // ----------------------------------------
  plb_logic_block #(.RAM_CAPABLE(1'b1)) plb_logic_block_inst (.clock(clock), .rst(rst), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .fabricIn(fabricIn), .topIn(topIn), .carryIn(carryIn), .fabricOut(fabricOut), .topOut(topOut),
    .carryOut(carryOut));
  plb_fabric plb_fabric_inst (.clock(clock), .fabricIn(fabricIn), .topIn(topIn), .carryIn(carryIn));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check_word(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Pin results are zero-extended into the word compare
  task automatic check_pins(input logic [3:0] g, input logic [3:0] e);
    check_word({28'h0, g}, {28'h0, e});
  endtask
  // One classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check_word(got, e);
  endtask
  // Pins pass two sync stages and an output register
  task automatic settle();
    repeat (6) @(posedge clock);
  endtask
  task automatic pulse(input int s);
    plb_fabric_inst.set_clk(s, 1'b1);
    plb_fabric_inst.set_clk(s, 1'b0);
    settle();
  endtask
  task automatic do_reset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Every word, an unmapped one and the read-only status after reset
  task automatic t_reset();
    for (int a = 0; a < 'h2c; a += 4) rd(a[7:0], 32'h0);
    wb(1'b1, 8'h24, 32'hffff_ffff);
    rd(8'h24, 32'h0);
    check_word({9'h0, carryOut, topOut, fabricOut}, 32'h0);
  endtask
  // Each table answers its own address pins, slice 3 included
  task automatic t_logic();
    do_reset();
    for (int i = 0; i < 4; i++) wb(1'b1, 8'(4*i), {16'h8000, 16'h0001 << (i+3)});
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 3; i++) plb_fabric_inst.set_slice(i, {5'h0, 4'(15-k), 4'(i+3+k)});
      plb_fabric_inst.set_top({2'b00, 4'(15-k), 4'(6+k)});
      settle();
      for (int i = 0; i < 3; i++) check_pins(4'(fabricOut[6*i +: 2]), k ? 4'h0 : 4'h3);
      check_pins(4'(topOut[1:0]), k ? 4'h0 : 4'h3);
      // With equal table results every merge stage shows that result
      for (int i = 0; i < 3; i++) check_pins(4'(fabricOut[6*i+4 +: 2]), k ? 4'h0 : 4'h3);
      check_pins(4'(topOut[3:2]), k ? 4'h0 : 4'h3);
    end
  endtask
  // Slice 0 registers load the select bits: edge, inverted edge, level
  task automatic t_clock();
    do_reset();
    wb(1'b1, 8'h10, 32'h080);
    plb_fabric_inst.set_slice(0, {3'b100, 2'b01, 8'h0});
    settle();
    check_pins(4'(fabricOut[3:2]), 4'h0);
    pulse(0);
    check_pins(4'(fabricOut[3:2]), 4'h1);
    plb_fabric_inst.set_clk(0, 1'b1);
    wb(1'b1, 8'h10, 32'h084);
    plb_fabric_inst.set_slice(0, {3'b101, 2'b10, 8'h0});
    settle();
    check_pins(4'(fabricOut[3:2]), 4'h1);
    plb_fabric_inst.set_clk(0, 1'b0);
    settle();
    check_pins(4'(fabricOut[3:2]), 4'h2);
    wb(1'b1, 8'h10, 32'h088);
    plb_fabric_inst.set_slice(0, {3'b101, 2'b11, 8'h0});
    settle();
    check_pins(4'(fabricOut[3:2]), 4'h3);
    plb_fabric_inst.set_slice(0, {3'b100, 2'b00, 8'h0});
    settle();
    check_pins(4'(fabricOut[3:2]), 4'h3);
  endtask
  // Slice 1 set/reset, asynchronous then synchronous, over clock enable
  task automatic t_setreset();
    do_reset();
    wb(1'b1, 8'h14, 32'h0d0);
    plb_fabric_inst.set_slice(1, {3'b110, 2'b00, 8'h0});
    settle();
    check_pins(4'(fabricOut[9:8]), 4'h2);
    plb_fabric_inst.set_slice(1, {3'b100, 2'b01, 8'h0});
    pulse(1);
    check_pins(4'(fabricOut[9:8]), 4'h1);
    wb(1'b1, 8'h14, 32'h0c0);
    plb_fabric_inst.set_slice(1, {3'b110, 2'b01, 8'h0});
    settle();
    check_pins(4'(fabricOut[9:8]), 4'h1);
    pulse(1);
    check_pins(4'(fabricOut[9:8]), 4'h2);
  endtask
  // All-propagate chain; slice 3 refuses ripple and stays logic
  task automatic t_ripple();
    do_reset();
    for (int i = 0; i < 4; i++) wb(1'b1, 8'(4*i), 32'hffff_ffff);
    for (int i = 0; i < 4; i++) wb(1'b1, 8'(16+4*i), 32'h1);
    for (int c = 1; c >= 0; c--) begin
      plb_fabric_inst.set_carry(c[0]);
      settle();
      for (int i = 0; i < 3; i++) check_pins(4'(fabricOut[6*i +: 2]), c ? 4'h0 : 4'h3);
      check_pins({3'h0, carryOut}, 4'(c));
      check_pins(4'(topOut[1:0]), 4'h3);
    end
  endtask
  // Slice 2 memory: written only with enable, read from address pins
  task automatic t_memory();
    do_reset();
    wb(1'b1, 8'h18, 32'h003);
    wb(1'b1, 8'h20, 32'h001);
    plb_fabric_inst.set_slice(2, {3'b100, 2'b11, 4'h5, 4'h5});
    pulse(2);
    check_pins(4'(fabricOut[13:12]), 4'h3);
    plb_fabric_inst.set_slice(2, {3'b000, 2'b00, 4'h5, 4'h5});
    pulse(2);
    check_pins(4'(fabricOut[13:12]), 4'h3);
    plb_fabric_inst.set_slice(2, {3'b000, 2'b00, 4'h5, 4'h6});
    settle();
    check_pins(4'(fabricOut[13:12]), 4'h2);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    mismatches = 0;
    num_checks = 0;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_logic();
    t_clock();
    t_setreset();
    t_ripple();
    t_memory();
    print_verdict();
  end
  // Whole run needs about 300 cycles; cut off at 20000
  initial begin
    #(40 * 20000);
    mismatches++;
    print_verdict();
  end
endmodule
